// ==== hdl/sfr_top.sv ====
// Purpose: transmit/receive request flags, dma and interrupt requests
// Assumes: fifo levels and receive head come from the same clock domain
// Notes: classic Wishbone slave, every access answered one cycle later
`include "sfr_defines.svh"
`default_nettype none

// Function
// RULE1: empty flag set raises transmit fill request
// RULE2: full flag set raises receive drain request
// RULE3: transmit fill request also requests dma
// RULE4: empty flag clears by zero after one read
// RULE5: full flag clears by zero after one read
// RULE6: low transmit level sets empty flag again
// RULE7: receive level above trigger sets full again
// RULE8: servicer fills past trigger before clearing
// RULE9: servicer drains receive data before clearing
// RULE10: full flag requests dma for receive reads
// RULE11: set condition beats a simultaneous clear
module sfr_top import sfr_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire sfr_lvl_t tx_level_i,
    input wire sfr_lvl_t rx_level_i,
    input wire logic [7:0] rx_data_i,
    output logic tx_push_o,
    output logic [7:0] tx_data_o,
    output logic rx_pop_o,
    output logic tx_fill_request_o,
    output logic rx_drain_request_o,
    output logic dma_tx_req_o,
    output logic dma_rx_req_o,
    output logic irq_o
);
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // byte-lane merge, shared by the ctrl, trig and irq mask registers
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    sfr_bus_t bus_q;
    sfr_bus_t bus_d;
    logic [31:0] rd_dat_q;
    logic [31:0] rd_dat_d;
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;
    sfr_trig_t tx_trig_q;
    sfr_trig_t tx_trig_d;
    sfr_trig_t rx_trig_q;
    sfr_trig_t rx_trig_d;
    sfr_ev_t mask_q;
    sfr_ev_t mask_d;
    sfr_ev_t irq_stat_q;
    sfr_ev_t irq_stat_d;
    logic tx_push_q;
    logic [7:0] tx_data_q;
    logic rx_pop_q;

    logic req;
    logic take;
    logic take_wr;
    logic take_rd;
    logic sel_status;
    logic sel_ctrl;
    logic sel_trig;
    logic sel_txport;
    logic sel_rxport;
    logic sel_irq_stat;
    logic sel_irq_mask;
    logic sel_level;
    logic [31:0] rdata_w;
    logic [31:0] ctrl_wv;
    logic [31:0] trig_wv;
    logic [31:0] mask_wv;
    logic [31:0] ctrl_rv;
    logic [31:0] trig_rv;
    logic [31:0] mask_rv;
    logic [31:0] status_rv;
    logic [31:0] irq_rv;
    logic [31:0] level_rv;
    logic [31:0] rxport_rv;

    logic tx_cond;
    logic rx_cond;
    logic st_wr;
    logic tx_flag;
    logic rx_flag;
    logic tx_set_ev;
    logic rx_set_ev;
    logic tx_refused;
    logic rx_refused;
    logic push_refused;
    logic pop_refused;
    logic tx_full;
    logic rx_empty;
    sfr_ev_t ev_w;
    sfr_ev_t w1c_w;

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    // an access takes effect only at the edge where ack is sampled high
    assign req = wb_cyc_i & wb_stb_i;
    assign take = req & (bus_q == SFR_ANSWER);
    assign take_wr = take & wb_we_i;
    assign take_rd = take & ~wb_we_i;

    // address decode, unmapped words read zero and ignore writes
    assign sel_status = (wb_adr_i == `SFR_OFS_STATUS);
    assign sel_ctrl = (wb_adr_i == `SFR_OFS_CTRL);
    assign sel_trig = (wb_adr_i == `SFR_OFS_TRIG);
    assign sel_txport = (wb_adr_i == `SFR_OFS_TXPORT);
    assign sel_rxport = (wb_adr_i == `SFR_OFS_RXPORT);
    assign sel_irq_stat = (wb_adr_i == `SFR_OFS_IRQ_STAT);
    assign sel_irq_mask = (wb_adr_i == `SFR_OFS_IRQ_MASK);
    assign sel_level = (wb_adr_i == `SFR_OFS_LEVEL);

    // ------------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------------
    // register images with reserved bits at zero
    assign status_rv = {30'h0, rx_flag, tx_flag};
    assign ctrl_rv = {30'h0, ctrl_q};
    assign trig_rv = {20'h0, rx_trig_q, 4'h0, tx_trig_q};
    assign mask_rv = {29'h0, mask_q};
    assign irq_rv = {29'h0, irq_stat_q};
    assign level_rv = {19'h0, rx_level_i, 3'h0, tx_level_i};
    // an empty receive fifo returns zero rather than a stale head
    assign rxport_rv = rx_empty ? 32'h0 : {24'h0, rx_data_i};

    assign rdata_w = sel_status ? status_rv :
                     sel_ctrl ? ctrl_rv :
                     sel_trig ? trig_rv :
                     sel_rxport ? rxport_rv :
                     sel_irq_stat ? irq_rv :
                     sel_irq_mask ? mask_rv :
                     sel_level ? level_rv : 32'h0;

    // ------------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------------
    // read image captured in the request cycle, ack one cycle later
    always_comb begin
        bus_d = bus_q;
        rd_dat_d = rd_dat_q;
        case (bus_q)
            SFR_IDLE: begin
                if (req) begin
                    bus_d = SFR_ANSWER;
                    rd_dat_d = wb_we_i ? 32'h0 : rdata_w;
                end
            end
            SFR_ANSWER: begin
                bus_d = SFR_IDLE;
            end
            default: begin
                bus_d = SFR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_q <= SFR_IDLE;
            rd_dat_q <= 32'h0;
        end else begin
            bus_q <= bus_d;
            rd_dat_q <= rd_dat_d;
        end
    end

    assign wb_ack_o = (bus_q == SFR_ANSWER);
    assign wb_dat_o = rd_dat_q;

    // ------------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------------
    // byte lanes honoured, unused lanes keep their value
    assign ctrl_wv = lane_merge(ctrl_rv, wb_dat_i, wb_sel_i);
    assign trig_wv = lane_merge(trig_rv, wb_dat_i, wb_sel_i);
    assign mask_wv = lane_merge(mask_rv, wb_dat_i, wb_sel_i);

    assign ctrl_d = (take_wr & sel_ctrl) ? ctrl_wv[1:0] : ctrl_q;
    assign tx_trig_d = (take_wr & sel_trig) ? trig_wv[`SFR_TXTRIG_LSB +: 4] : tx_trig_q;
    assign rx_trig_d = (take_wr & sel_trig) ? trig_wv[`SFR_RXTRIG_LSB +: 4] : rx_trig_q;
    assign mask_d = (take_wr & sel_irq_mask) ? mask_wv[2:0] : mask_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `SFR_RST_CTRL;
            tx_trig_q <= `SFR_RST_TXTRIG;
            rx_trig_q <= `SFR_RST_RXTRIG;
            mask_q <= `SFR_RST_MASK;
        end else begin
            ctrl_q <= ctrl_d;
            tx_trig_q <= tx_trig_d;
            rx_trig_q <= rx_trig_d;
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------------------
    // fifo ports
    // ------------------------------------------------------------------------
    // pushes into a full fifo and pops from an empty one are dropped
    assign tx_full = (tx_level_i >= `SFR_FIFO_DEPTH);
    assign rx_empty = (rx_level_i == 5'h00);
    assign push_refused = take_wr & sel_txport & wb_sel_i[0] & tx_full;
    assign pop_refused = take_rd & sel_rxport & rx_empty;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_push_q <= 1'b0;
            tx_data_q <= 8'h00;
            rx_pop_q <= 1'b0;
        end else begin
            tx_push_q <= take_wr & sel_txport & wb_sel_i[0] & ~tx_full;
            if (take_wr & sel_txport & wb_sel_i[0]) begin
                tx_data_q <= wb_dat_i[7:0];
            end
            rx_pop_q <= take_rd & sel_rxport & ~rx_empty;
        end
    end

    assign tx_push_o = tx_push_q;
    assign tx_data_o = tx_data_q;
    assign rx_pop_o = rx_pop_q;

    // ------------------------------------------------------------------------
    // request flags
    // ------------------------------------------------------------------------
    // trigger compare: transmit at or below, receive strictly above
    assign tx_cond = (tx_level_i <= {1'b0, tx_trig_q}); // [RULE6]
    assign rx_cond = (rx_level_i > {1'b0, rx_trig_q}); // [RULE7]
    // only lane 0 carries the flag bits
    assign st_wr = take_wr & sel_status & wb_sel_i[0];

    // arming uses the very image returned to the reader
    sfr_req_flag u_tx_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rst_val_i(`SFR_RST_TXF),
        .cond_i(tx_cond),
        .rd_seen_i(take_rd & sel_status & rd_dat_q[`SFR_BIT_TXF]), // [RULE4]
        .wr_i(st_wr),
        .wr_bit_i(wb_dat_i[`SFR_BIT_TXF]),
        .flag_o(tx_flag),
        .set_ev_o(tx_set_ev),
        .refused_o(tx_refused)
    );

    sfr_req_flag u_rx_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rst_val_i(`SFR_RST_RXF),
        .cond_i(rx_cond),
        .rd_seen_i(take_rd & sel_status & rd_dat_q[`SFR_BIT_RXF]), // [RULE5]
        .wr_i(st_wr),
        .wr_bit_i(wb_dat_i[`SFR_BIT_RXF]),
        .flag_o(rx_flag),
        .set_ev_o(rx_set_ev),
        .refused_o(rx_refused)
    );

    // requests follow the flags directly, dma gated by its enables
    assign tx_fill_request_o = tx_flag; // [RULE1]
    assign rx_drain_request_o = rx_flag; // [RULE2]
    assign dma_tx_req_o = tx_flag & ctrl_q[`SFR_BIT_TXDMA]; // [RULE3]
    assign dma_rx_req_o = rx_flag & ctrl_q[`SFR_BIT_RXDMA]; // [RULE10]

    // ------------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------------
    // a new event beats a write-one-to-clear in the same cycle
    assign ev_w[`SFR_EV_TX] = tx_set_ev;
    assign ev_w[`SFR_EV_RX] = rx_set_ev;
    assign ev_w[`SFR_EV_REFUSE] = tx_refused | rx_refused | push_refused | pop_refused;
    assign w1c_w = (take_wr & sel_irq_stat & wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;
    assign irq_stat_d = ev_w | (irq_stat_q & ~w1c_w);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    assign irq_o = |(irq_stat_q & mask_q);

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    tx_request_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
        $rose(u_tx_flag.flag_q) |-> tx_fill_request_o && $past(tx_cond))
        else $error("transmit fill request not tied to empty flag");
    rx_request_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
        $rose(rx_drain_request_o) |-> $past(rx_cond))
        else $error("receive drain request rose without full condition");
    tx_dma_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
        (take_wr && sel_ctrl && ctrl_wv[0] && tx_cond) |=> dma_tx_req_o)
        else $error("transmit dma request missing");
    rx_dma_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
        dma_rx_req_o |-> rx_drain_request_o && ctrl_q[1])
        else $error("receive dma request without full flag");
    tx_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
        (tx_level_i <= {1'b0, tx_trig_q}) |=> tx_fill_request_o)
        else $error("empty flag not set again at low level");
    rx_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
        (rx_level_i > {1'b0, rx_trig_q}) |=> rx_drain_request_o)
        else $error("full flag not set again above trigger");
    rx_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
        $fell(rx_drain_request_o) |-> $past(st_wr) && !$past(rx_cond))
        else $error("full flag cleared without a status write");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after one wait");
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_set_ev && mask_q[0] && !(take_wr && sel_irq_mask)) |=> irq_o)
        else $error("unmasked event did not raise interrupt");
endmodule // sfr_top

`default_nettype wire

// ==== shared/sfr_defines.svh ====
// Purpose: offsets, field positions and reset values of the request-flag block
// Assumes: byte addresses on a 32-bit classic Wishbone bus, one register per word
// Notes: included by the package users only by bare name
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SFR_OFS_STATUS 8'h00
`define SFR_OFS_CTRL 8'h04
`define SFR_OFS_TRIG 8'h08
`define SFR_OFS_TXPORT 8'h0C
`define SFR_OFS_RXPORT 8'h10
`define SFR_OFS_IRQ_STAT 8'h14
`define SFR_OFS_IRQ_MASK 8'h18
`define SFR_OFS_LEVEL 8'h1C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SFR_BIT_TXF 0
`define SFR_BIT_RXF 1
`define SFR_BIT_TXDMA 0
`define SFR_BIT_RXDMA 1
`define SFR_TXTRIG_LSB 0
`define SFR_RXTRIG_LSB 8
`define SFR_TXLVL_LSB 0
`define SFR_RXLVL_LSB 8
`define SFR_EV_TX 0
`define SFR_EV_RX 1
`define SFR_EV_REFUSE 2

// ----------------------------------------------------------------------------
// reset values and fifo size
// ----------------------------------------------------------------------------
`define SFR_RST_CTRL 2'h0
`define SFR_RST_TXTRIG 4'h8
`define SFR_RST_RXTRIG 4'h0
`define SFR_RST_MASK 3'h0
`define SFR_RST_TXF 1'b1
`define SFR_RST_RXF 1'b0
`define SFR_FIFO_DEPTH 5'h10

`endif

// ==== shared/sfr_pkg.sv ====
// Purpose: types shared by the request-flag block
// Assumes: 16-entry fifos outside the block, levels 0..16
// Notes: numbers live in sfr_defines.svh
`default_nettype none

package sfr_pkg;
    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef logic [4:0] sfr_lvl_t;
    typedef logic [3:0] sfr_trig_t;
    typedef logic [2:0] sfr_ev_t;
    typedef enum logic [0:0] {
        SFR_IDLE = 1'b0,
        SFR_ANSWER = 1'b1
    } sfr_bus_t;
endpackage : sfr_pkg

`default_nettype wire

// ==== hdl/sfr_req_flag.sv ====
// Purpose: one request flag with read-one-then-write-zero clearing
// Assumes: set condition comes from same-clock logic
// Notes: set condition beats a clearing write in the same cycle
`default_nettype none

module sfr_req_flag (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rst_val_i,
    input wire logic cond_i,
    input wire logic rd_seen_i,
    input wire logic wr_i,
    input wire logic wr_bit_i,
    output logic flag_o,
    output logic set_ev_o,
    output logic refused_o
);
    logic flag_q;
    logic flag_d;
    logic armed_q;
    logic armed_d;
    logic clear_ok;

    // a zero write clears only once the one has been seen by a read
    assign clear_ok = wr_i & ~wr_bit_i & armed_q; // [RULE4] [RULE5]
    // level still on the wrong side of trigger keeps the flag up
    assign flag_d = cond_i | (flag_q & ~clear_ok); // [RULE6] [RULE7] [RULE11]
    // any status write with lane 0 selected consumes the arming
    assign armed_d = wr_i ? 1'b0 : (armed_q | (rd_seen_i & flag_q));
    assign set_ev_o = flag_d & ~flag_q;
    assign refused_o = wr_i & ~wr_bit_i & flag_q & ~armed_q;
    assign flag_o = flag_q;

    // rst_val_i is a tie-off; reset is synchronous so it is a plain load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= rst_val_i;
            armed_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            armed_q <= armed_d;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    clear_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
        $fell(flag_q) |-> $past(armed_q) && $past(wr_i) && !$past(wr_bit_i))
        else $error("flag fell without a prior read of one");
    set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
        (wr_i && !wr_bit_i && cond_i) |=> flag_q)
        else $error("clearing write beat the set condition");
endmodule // sfr_req_flag

`default_nettype wire

// ==== tb/sfr_fifo_model.sv ====
// Purpose: far-side model, the two fifos that the servicing party fills and drains
// Assumes: 16-byte fifos, levels and head byte registered on clk_i
// Notes: an empty receive fifo shows a head byte that toggles every cycle
`default_nettype none

module sfr_fifo_model import sfr_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tx_push_i,
    input wire logic [7:0] tx_data_i,
    input wire logic rx_pop_i,
    input wire logic tx_take_i,
    input wire logic rx_put_i,
    input wire logic [7:0] rx_put_data_i,
    output sfr_lvl_t tx_level_o,
    output sfr_lvl_t rx_level_o,
    output logic [7:0] rx_head_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];

    // ------------------------------------------------------------------------
    // fifo storage
    // ------------------------------------------------------------------------
    initial begin
        tx_level_o = '0;
        rx_level_o = '0;
        rx_head_o = 8'h00;
    end

    // pushes from the block fill the transmit side, the serial engine takes them
    always @(posedge clk_i) begin
        if (rst_i) begin
            txq.delete();
            rxq.delete();
        end else begin
            if (tx_push_i && txq.size() < 16) txq.push_back(tx_data_i);
            if (tx_take_i && txq.size() > 0) void'(txq.pop_front());
            if (rx_put_i && rxq.size() < 16) rxq.push_back(rx_put_data_i);
            if (rx_pop_i && rxq.size() > 0) void'(rxq.pop_front());
        end
        tx_level_o <= sfr_lvl_t'(txq.size());
        rx_level_o <= sfr_lvl_t'(rxq.size());
        // no stale byte when empty, so a late read cannot pass by luck
        rx_head_o <= (rxq.size() > 0) ? rxq[0] : ~rx_head_o;
    end
endmodule // sfr_fifo_model

`default_nettype wire

// ==== tb/tb_serial_fifo_request_flags.sv ====
// Purpose: self-checking bench for the request-flag block
// Assumes: ack one cycle after a request is seen, flags follow level one cycle later
// Notes: bench acts as the servicing party and keeps its own byte queues
`default_nettype none

module tb_serial_fifo_request_flags import sfr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, tx_push, rx_pop, txr, rxr, dtx, drx, irq;
    logic [7:0] tx_data, rx_head;
    sfr_lvl_t tx_level, rx_level;
    logic tx_take = 1'b0;
    logic rx_put = 1'b0;
    logic [7:0] rx_put_data = 8'h00;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;
    int tx_n = 0;
    int rx_n = 0;
    logic den = 1'b0;
    logic [31:0] seed = 32'h0000001F;
    logic [31:0] r;
    logic [7:0] exp_tx[$];
    logic [7:0] exp_rx[$];

    always #5 clk_i = ~clk_i;

    sfr_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_level_i(tx_level), .rx_level_i(rx_level), .rx_data_i(rx_head),
        .tx_push_o(tx_push), .tx_data_o(tx_data), .rx_pop_o(rx_pop),
        .tx_fill_request_o(txr), .rx_drain_request_o(rxr), .dma_tx_req_o(dtx),
        .dma_rx_req_o(drx), .irq_o(irq)
    );

    sfr_fifo_model u_fifo (
        .clk_i(clk_i), .rst_i(rst_i), .tx_push_i(tx_push), .tx_data_i(tx_data),
        .rx_pop_i(rx_pop), .tx_take_i(tx_take), .rx_put_i(rx_put),
        .rx_put_data_i(rx_put_data), .tx_level_o(tx_level), .rx_level_o(rx_level),
        .rx_head_o(rx_head)
    );

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (error_cnt == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // one classic cycle; the master holds everything until it samples ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) chk({31'h0, ack}, 32'h1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(r, e);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask

    // request outputs against the bench's flag model, dma gated by ctrl
    task automatic req(input logic et, input logic er);
        chk({28'h0, txr, rxr, dtx, drx}, {28'h0, et, er, et & den, er & den});
    endtask

    task automatic push(input int n);
        logic [7:0] d;
        repeat (n) begin
            d = 8'(xs());
            exp_tx.push_back(d);
            tx_n++;
            wb(1'b1, 8'h0C, {24'h0, d});
        end
    endtask

    task automatic put(input int n);
        repeat (n) begin
            @(posedge clk_i);
            rx_put <= 1'b1;
            rx_put_data <= 8'(xs());
            @(posedge clk_i);
            exp_rx.push_back(rx_put_data);
            rx_n++;
            rx_put <= 1'b0;
        end
    endtask

    // ------------------------------------------------------------------------
    // monitors and watchdog
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_i && tx_push === 1'b1) begin
            if (exp_tx.size() > 0) chk({24'h0, tx_data}, {24'h0, exp_tx.pop_front()});
            else chk({31'h0, tx_push}, 32'h0);
        end
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        req(1'b1, 1'b0);
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h8);
        rd(8'h18, 32'h0);
        rd(8'h24, 32'h0);
        wb(1'b1, 8'h04, 32'h3);
        den = 1'b1;
        wb(1'b1, 8'h08, 32'h208);
        wb(1'b1, 8'h18, 32'h4);
        chk({31'h0, irq}, 32'h0);
        // armed clear while the level sits below the trigger: flag must survive
        rd(8'h00, 32'h1);
        wb(1'b1, 8'h00, 32'h2);
        settle();
        req(1'b1, 1'b0);
        push(9);
        settle();
        rd(8'h1C, (rx_n << 8) | tx_n);
        // zero write without a read of one is ignored and refused
        wb(1'b1, 8'h00, 32'h2);
        settle();
        req(1'b1, 1'b0);
        chk({31'h0, irq}, 32'h1);
        wb(1'b0, 8'h14, 32'h0);
        chk(r & 32'h4, 32'h4);
        wb(1'b1, 8'h18, 32'h0);
        settle();
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, 8'h18, 32'h4);
        settle();
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h14, 32'h5);
        settle();
        chk({31'h0, irq}, 32'h0);
        rd(8'h00, 32'h1);
        wb(1'b1, 8'h00, 32'h2);
        settle();
        req(1'b0, 1'b0);
        wb(1'b0, 8'h14, 32'h0);
        chk(r & 32'h1, 32'h0);
        // serial engine takes one byte: level back on the trigger re-sets the flag
        @(posedge clk_i);
        tx_take <= 1'b1;
        @(posedge clk_i);
        tx_take <= 1'b0;
        tx_n--;
        settle();
        req(1'b1, 1'b0);
        wb(1'b0, 8'h14, 32'h0);
        chk(r & 32'h1, 32'h1);
        // receive side: level equal to the trigger does not set
        put(2);
        settle();
        req(1'b1, 1'b0);
        put(1);
        settle();
        req(1'b1, 1'b1);
        rd(8'h00, 32'h3);
        wb(1'b1, 8'h00, 32'h1);
        settle();
        req(1'b1, 1'b1);
        repeat (3) begin
            wb(1'b0, 8'h10, 32'h0);
            chk(r, {24'h0, exp_rx.pop_front()});
            rx_n--;
        end
        settle();
        rd(8'h1C, (rx_n << 8) | tx_n);
        req(1'b1, 1'b1);
        rd(8'h00, 32'h3);
        wb(1'b1, 8'h00, 32'h1);
        settle();
        req(1'b1, 1'b0);
        // pop from an empty receive fifo reads zero and is flagged as refused
        wb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        wb(1'b0, 8'h14, 32'h0);
        chk(r & 32'h4, 32'h4);
        conclude();
    end
endmodule // tb_serial_fifo_request_flags

`default_nettype wire
